/* core/lsp_pkg.sv */
package lsp_pkg;
    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [7:0] ADDR_IDX = 8'h5c; // Software node address
    localparam logic [7:0] REACT_IDX = 8'h5d; // Fault reaction config
    localparam logic [7:0] SAFE_IDX = 8'h5e; // Safe position target
    localparam logic [7:0] IRQ_STAT_IDX = 8'h60; // Sticky event status
    localparam logic [7:0] IRQ_MASK_IDX = 8'h61; // Event mask
    localparam logic [7:0] STATE_IDX = 8'h62; // Live state
    localparam logic [7:0] SAVE_IDX = 8'h63; // Save command
    localparam int REG_AW = 10; // Byte address width
    // ----------------------------------------
    // Reset values and save key
    // ----------------------------------------
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] REACT_RST = 16'h0001;
    localparam logic [31:0] SAFE_RST = 32'h0000_0000;
    localparam logic [15:0] SAVE_KEY = 16'h0001; // Write value that saves
    // ----------------------------------------
    // Reaction field positions and codes
    // ----------------------------------------
    localparam int LOSS_LSB = 0;
    localparam int PWRUP_LSB = 2;
    localparam int BAD_LSB = 4;
    localparam logic [1:0] RC_CONTINUE = 2'h0;
    localparam logic [1:0] RC_ABORT = 2'h1;
    localparam logic [1:0] RC_SAFE = 2'h2;
    localparam logic [1:0] RC_RSVD = 2'h3;
    // ----------------------------------------
    // Event bits
    // ----------------------------------------
    localparam int EV_LOSS = 0;
    localparam int EV_BAD = 1;
    localparam int EV_PWRUP = 2;
    localparam int EV_W = 3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam int T15_S = 15;
    localparam int T30_S = 30;
    localparam int T60_S = 60;
    localparam int TICK_MS = 1; // Tick period
    localparam int TICK_CYC = int'(CLK_HZ / 1000 * TICK_MS);
    localparam int T15_TICKS = T15_S * 1000 / TICK_MS;
    localparam int T30_TICKS = T30_S * 1000 / TICK_MS;
    localparam int T60_TICKS = T60_S * 1000 / TICK_MS;
endpackage

/* core/lsp_tick.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Divider: one-cycle enable every DIV cycles
// ----------------------------------------
module lsp_tick #(
    parameter int DIV = 100_000
) (
    input wire logic clk,
    input wire logic srst,
    output logic tick
);
    logic [31:0] cnt_q; // Cycle counter

    // Count up, wrap and pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_q >= 32'(DIV - 1)) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule

/* core/lsp_core.sv */
`timescale 1ns/1ps
module lsp_core #(
    parameter int TICK_CYC = lsp_pkg::TICK_CYC,
    parameter int T15_TICKS = lsp_pkg::T15_TICKS,
    parameter int T30_TICKS = lsp_pkg::T30_TICKS,
    parameter int T60_TICKS = lsp_pkg::T60_TICKS
) (
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [lsp_pkg::REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins are asynchronous; all pass the synchronisers below
    // Device pins and link status
    input wire logic switches_fitted,
    input wire logic [7:0] switch_addr,
    input wire logic link_up,
    input wire logic iops_bad,
    input wire logic restart_req,
    // Outputs to naming and motion
    output logic [15:0] node_addr,
    output logic use_sw_name,
    output logic use_switch_addr,
    output logic use_ctrl_name,
    output logic save_pulse,
    output logic abort_req,
    output logic safe_run_req,
    output logic [31:0] safe_target,
    output logic irq
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Every pin runs three flops deep; a level is taken only when
    // the last two agree, which also filters one-cycle glitches
    logic [2:0] up_s_q; // Link up, three stages
    logic [2:0] bad_s_q; // IOPS BAD, three stages
    logic [2:0] fit_s_q; // Switches fitted
    logic [2:0] rst_s_q; // Restart request
    logic [7:0] sw_s1_q, sw_s2_q, sw_s3_q; // Switch value
    logic up_q, bad_q, fit_q, rstreq_q; // Filtered levels
    logic [7:0] sw_q; // Filtered switches

    // Shift pins in; stage 0 read only by stage 1
    always_ff @(posedge clk) begin
        up_s_q <= {up_s_q[1:0], link_up};
        bad_s_q <= {bad_s_q[1:0], iops_bad};
        fit_s_q <= {fit_s_q[1:0], switches_fitted};
        rst_s_q <= {rst_s_q[1:0], restart_req};
        sw_s1_q <= switch_addr;
        sw_s2_q <= sw_s1_q;
        sw_s3_q <= sw_s2_q;
    end

    // Reset clears only the filtered levels; the raw stages need none
    // Accept a change once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            up_q <= 1'b0;
            bad_q <= 1'b0;
            fit_q <= 1'b0;
            rstreq_q <= 1'b0;
            sw_q <= 8'h00;
        end else begin
            if (up_s_q[1] == up_s_q[2]) up_q <= up_s_q[2];
            if (bad_s_q[1] == bad_s_q[2]) bad_q <= bad_s_q[2];
            if (fit_s_q[1] == fit_s_q[2]) fit_q <= fit_s_q[2];
            if (rst_s_q[1] == rst_s_q[2]) rstreq_q <= rst_s_q[2];
            if (sw_s2_q == sw_s3_q) sw_q <= sw_s3_q;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Shared by the loss and provider-bad fields
    // Reserved code maps to abort so a fault never runs on
    function automatic logic [1:0] eff_code(input logic [1:0] c);
        eff_code = (c == lsp_pkg::RC_RSVD) ? lsp_pkg::RC_ABORT : c;
    endfunction

    // Register decode on a word-aligned byte address
    function automatic logic hit(input logic [lsp_pkg::REG_AW-1:0] a, input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] addr_q; // Written software address
    logic [15:0] saved_addr_q; // Saved copy, survives restart
    logic [15:0] active_addr_q; // Address in effect
    logic [15:0] react_q; // Reaction config
    logic [31:0] safe_q; // Signed safe target
    logic [lsp_pkg::EV_W-1:0] stat_q; // Sticky events
    logic [lsp_pkg::EV_W-1:0] mask_q; // Event mask
    logic [lsp_pkg::EV_W-1:0] ev; // Event pulses this cycle

    // Only the low half is kept for the 16-bit registers
    // Parameter writes
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_q <= lsp_pkg::ADDR_RST;
            react_q <= lsp_pkg::REACT_RST;
            safe_q <= lsp_pkg::SAFE_RST;
        end else if (reg_wr) begin
            if (hit(reg_addr, lsp_pkg::ADDR_IDX)) addr_q <= reg_wdata[15:0];
            if (hit(reg_addr, lsp_pkg::REACT_IDX)) react_q <= reg_wdata[15:0];
            if (hit(reg_addr, lsp_pkg::SAFE_IDX)) safe_q <= reg_wdata;
        end
    end

    // Any other value in the low half written to the save index does nothing
    // Save command latches the address for the next restart
    always_ff @(posedge clk) begin
        if (srst) begin
            save_pulse <= 1'b0;
        end else begin
            save_pulse <= reg_wr && hit(reg_addr, lsp_pkg::SAVE_IDX)
                && (reg_wdata[15:0] == lsp_pkg::SAVE_KEY);
        end
    end

    // Limitation: unknown until the first save after power-on
    // Saved copy is nonvolatile in spirit: srst does not clear it
    always_ff @(posedge clk) begin
        if (save_pulse) begin
            saved_addr_q <= addr_q;
        end
    end

    // A write alone never reaches the naming logic; only a save followed by a restart does
    // A held restart request just keeps reloading, which is harmless
    // Active address only loads at restart, never on write
    logic restarting_q; // Restart in progress
    always_ff @(posedge clk) begin
        if (srst) begin
            restarting_q <= 1'b1;
            active_addr_q <= lsp_pkg::ADDR_RST;
        end else if (restarting_q || rstreq_q) begin
            restarting_q <= 1'b0;
            active_addr_q <= saved_addr_q;
        end
    end

    // ----------------------------------------
    // Address and name selection
    // ----------------------------------------
    logic sw_zero; // Switches absent or 00
    assign sw_zero = !fit_q || (sw_q == 8'h00);

    // Priority: switches, then software address, then controller name
    // Exactly one source is named in every branch except reset, which names none
    // Registered naming outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            node_addr <= 16'h0000;
            use_sw_name <= 1'b0;
            use_switch_addr <= 1'b0;
            use_ctrl_name <= 1'b0;
        end else if (!sw_zero) begin
            node_addr <= {8'h00, sw_q};
            use_sw_name <= 1'b0;
            use_switch_addr <= 1'b1;
            use_ctrl_name <= 1'b0;
        end else if (active_addr_q != 16'h0000) begin
            node_addr <= active_addr_q;
            use_sw_name <= 1'b1;
            use_switch_addr <= 1'b0;
            use_ctrl_name <= 1'b0;
        end else begin
            node_addr <= 16'h0000;
            use_sw_name <= 1'b0;
            use_switch_addr <= 1'b0;
            use_ctrl_name <= 1'b1;
        end
    end

    // ----------------------------------------
    // Link supervision
    // ----------------------------------------
    // Link timing counts in ticks so the compare stays cheap
    logic up_d1_q, bad_d1_q; // Previous levels
    logic seen_q; // Link has existed
    logic pwr_wait_q; // Power-up wait running
    logic [31:0] ms_q; // Elapsed ticks
    logic tick; // Millisecond enable

    // One divider serves every slow count in the block
    lsp_tick #(.DIV(TICK_CYC)) u_tick (
        .clk(clk),
        .srst(srst),
        .tick(tick)
    );

    // Code 0 gives no limit; the event logic ignores it then
    logic [1:0] pwr_code; // Power-up field
    logic [31:0] pwr_limit; // Tick count for field
    assign pwr_code = react_q[lsp_pkg::PWRUP_LSB +: 2];
    always_comb begin
        case (pwr_code)
            2'h1: pwr_limit = 32'(T15_TICKS);
            2'h2: pwr_limit = 32'(T30_TICKS);
            2'h3: pwr_limit = 32'(T60_TICKS);
            default: pwr_limit = 32'h0000_0000;
        endcase
    end

    // seen_q never clears outside reset, so a second loss still reacts
    // Edge history and connection memory
    always_ff @(posedge clk) begin
        if (srst) begin
            up_d1_q <= 1'b0;
            bad_d1_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            up_d1_q <= up_q;
            bad_d1_q <= bad_q;
            if (up_q) seen_q <= 1'b1;
        end
    end

    // Power-up timer; stops for good once a link appears
    // Code 0 only pauses it: the field is written after reset, so stopping
    // here would make the power-up run unreachable
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_wait_q <= 1'b1;
            ms_q <= 32'h0000_0000;
        end else if (up_q || seen_q) begin
            pwr_wait_q <= 1'b0;
        end else if (pwr_wait_q && tick && pwr_code != 2'h0) begin
            ms_q <= ms_q + 32'h0000_0001;
            if (ms_q + 32'h0000_0001 >= pwr_limit) pwr_wait_q <= 1'b0;
        end
    end

    // Each event is a single-cycle pulse; loss and provider-bad come from a filtered edge
    // A loss before any connection cannot fire: seen_q gates it
    // Event pulses
    always_comb begin
        ev = '0;
        // Bit order matches the status register
        ev[lsp_pkg::EV_LOSS] = seen_q && up_d1_q && !up_q;
        ev[lsp_pkg::EV_BAD] = bad_q && !bad_d1_q;
        ev[lsp_pkg::EV_PWRUP] = pwr_wait_q && tick && !up_q && !seen_q
            && (pwr_code != 2'h0) && (ms_q + 32'h0000_0001 >= pwr_limit);
    end

    // ----------------------------------------
    // Reaction
    // ----------------------------------------
    // Codes resolved once here and shared by both request pulses
    logic [1:0] loss_c, bad_c; // Effective codes
    assign loss_c = eff_code(react_q[lsp_pkg::LOSS_LSB +: 2]);
    assign bad_c = eff_code(react_q[lsp_pkg::BAD_LSB +: 2]);

    // Trade-off: pulses, not levels, so the motion side must latch them
    // Requests: one-cycle pulses; continue raises nothing
    always_ff @(posedge clk) begin
        if (srst) begin
            abort_req <= 1'b0;
            safe_run_req <= 1'b0;
        end else begin
            abort_req <= (ev[lsp_pkg::EV_LOSS] && loss_c == lsp_pkg::RC_ABORT)
                || (ev[lsp_pkg::EV_BAD] && bad_c == lsp_pkg::RC_ABORT);
            safe_run_req <= (ev[lsp_pkg::EV_LOSS] && loss_c == lsp_pkg::RC_SAFE)
                || (ev[lsp_pkg::EV_BAD] && bad_c == lsp_pkg::RC_SAFE)
                || ev[lsp_pkg::EV_PWRUP];
        end
    end

    // Registered copy keeps the target steady beside each pulse
    // Target presented with each safe run
    always_ff @(posedge clk) begin
        if (srst) begin
            safe_target <= lsp_pkg::SAFE_RST;
        end else begin
            safe_target <= safe_q;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Clear and event in one cycle: the event stays visible
    // Set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            if (reg_wr && hit(reg_addr, lsp_pkg::IRQ_MASK_IDX)) begin
                mask_q <= reg_wdata[lsp_pkg::EV_W-1:0];
            end
            if (reg_wr && hit(reg_addr, lsp_pkg::IRQ_STAT_IDX)) begin
                stat_q <= (stat_q & ~reg_wdata[lsp_pkg::EV_W-1:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
        end
    end

    // Level interrupt, combinational from status and mask
    assign irq = |(stat_q & mask_q);

    // ----------------------------------------
    // Read data, valid one cycle after strobe
    // ----------------------------------------
    // Idle cycles read zero so stale data never lingers
    // Unmapped and write-only indices (the save command) read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr[lsp_pkg::REG_AW-1:2])
                lsp_pkg::ADDR_IDX: reg_rdata <= {16'h0000, addr_q};
                lsp_pkg::REACT_IDX: reg_rdata <= {16'h0000, react_q};
                lsp_pkg::SAFE_IDX: reg_rdata <= safe_q;
                lsp_pkg::IRQ_STAT_IDX: reg_rdata <= {29'h0, stat_q};
                lsp_pkg::IRQ_MASK_IDX: reg_rdata <= {29'h0, mask_q};
                lsp_pkg::STATE_IDX: reg_rdata <= {active_addr_q, 12'h000, pwr_wait_q, bad_q, seen_q, up_q};
                default: reg_rdata <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

/* test/lsp_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the link-fault core
// ----------------------------------------
module lsp_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic [lsp_pkg::REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic link_up,
    input wire logic iops_bad,
    input wire logic restart_req,
    input wire logic [15:0] node_addr,
    input wire logic use_sw_name,
    input wire logic use_switch_addr,
    input wire logic use_ctrl_name,
    input wire logic save_pulse,
    input wire logic abort_req,
    input wire logic safe_run_req
);
    localparam logic [lsp_pkg::REG_AW-1:0] a_save = {lsp_pkg::SAVE_IDX, 2'h0};
    localparam logic [lsp_pkg::REG_AW-1:0] a_addr = {lsp_pkg::ADDR_IDX, 2'h0};
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic save_wr; // Accepted save command
    assign save_wr = reg_wr && reg_addr == a_save && reg_wdata[15:0] == lsp_pkg::SAVE_KEY;
    save_pulse_a: assert property (save_wr |=> save_pulse)
        else $error("save write gave no pulse");
    save_cause_a: assert property (save_pulse |-> $past(save_wr))
        else $error("save pulse without save write");
    // Only a restart may move the address in effect
    addr_hold_a: assert property (reg_wr && reg_addr == a_addr && !restart_req |=> $stable(node_addr))
        else $error("address took effect at once");
    pulse_excl_a: assert property (!(abort_req && safe_run_req))
        else $error("abort and safe run together");
    abort_short_a: assert property (abort_req |=> !abort_req)
        else $error("abort pulse too long");
    safe_short_a: assert property (safe_run_req |=> !safe_run_req)
        else $error("safe run pulse too long");
    abort_cause_a: assert property (abort_req |-> !link_up || iops_bad)
        else $error("abort with healthy link");
    sw_name_a: assert property (use_sw_name |-> node_addr != 16'h0000)
        else $error("software name with zero address");
    name_src_a: assert property ($onehot0({use_sw_name, use_switch_addr, use_ctrl_name}))
        else $error("naming source not one-hot");
endmodule
bind lsp_core lsp_checker chk_u (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .link_up(link_up), .iops_bad(iops_bad), .restart_req(restart_req), .node_addr(node_addr),
    .use_sw_name(use_sw_name), .use_switch_addr(use_switch_addr), .use_ctrl_name(use_ctrl_name),
    .save_pulse(save_pulse), .abort_req(abort_req), .safe_run_req(safe_run_req)
);

/* test/lsp_ctrl_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// IO controller: link and provider status
// ----------------------------------------
module lsp_ctrl_model #(
    parameter int LAG = 1
) (
    input wire logic clk,
    input wire logic connect,
    input wire logic cpu_stop,
    output logic link_up,
    output logic iops_bad
);
    logic [7:0] dly_q; // Set-up delay; controller ignores device reset
    always_ff @(posedge clk) begin
        dly_q <= {dly_q[6:0], connect};
    end
    // Provider status only exists on a live link
    always_ff @(posedge clk) begin
        link_up <= dly_q[LAG-1];
        iops_bad <= dly_q[LAG-1] & cpu_stop;
    end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [7:0] ad = lsp_pkg::ADDR_IDX;
    localparam logic [7:0] re = lsp_pkg::REACT_IDX;
    localparam logic [7:0] sf = lsp_pkg::SAFE_IDX;
    localparam logic [7:0] st = lsp_pkg::IRQ_STAT_IDX;
    localparam logic [7:0] mk = lsp_pkg::IRQ_MASK_IDX;
    logic clk, srst, reg_wr, reg_rd, switches_fitted, restart_req, connect, cpu_stop, rd_q;
    logic link_up, iops_bad, use_sw_name, use_switch_addr, use_ctrl_name, save_pulse, abort_req, safe_run_req, irq;
    logic [9:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, safe_target, r;
    logic [15:0] node_addr;
    logic [7:0] switch_addr;
    logic [31:0] rdq[$]; // Expected read data
    logic [1:0] evq[$]; // Expected {abort, safe} pulses
    int errors, n_tests, n, lim;
    lsp_core #(.TICK_CYC(10), .T15_TICKS(3), .T30_TICKS(6), .T60_TICKS(12)) dut_u (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switches_fitted(switches_fitted),
        .switch_addr(switch_addr), .link_up(link_up), .iops_bad(iops_bad), .restart_req(restart_req),
        .node_addr(node_addr), .use_sw_name(use_sw_name), .use_switch_addr(use_switch_addr),
        .use_ctrl_name(use_ctrl_name), .save_pulse(save_pulse), .abort_req(abort_req),
        .safe_run_req(safe_run_req), .safe_target(safe_target), .irq(irq));
    // Slow controller to stretch link timing
    lsp_ctrl_model #(.LAG(3)) ctrl_u (
        .clk(clk), .connect(connect), .cpu_stop(cpu_stop), .link_up(link_up), .iops_bad(iops_bad));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic rst();
        srst <= 1'b1;
        wt(20);
        srst <= 1'b0;
        wt(1);
    endtask
    // Strobe, then one idle edge so strobes never collide
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        reg_addr <= {idx, 2'h0};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        wt(1);
        reg_wr <= 1'b0;
        wt(1);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        reg_addr <= {idx, 2'h0};
        reg_rd <= 1'b1;
        rdq.push_back(e);
        wt(1);
        reg_rd <= 1'b0;
        wt(1);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Monitor: pairs each result with oldest note
    // ----------------------------------------
    always @(posedge clk) begin
        rd_q <= reg_rd;
        if (rd_q) check(reg_rdata, rdq.size() ? rdq.pop_front() : 32'hdead_beef);
        if (abort_req || safe_run_req) begin
            check({30'h0, abort_req, safe_run_req}, evq.size() ? {30'h0, evq.pop_front()} : 32'h0);
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {srst, reg_wr, reg_rd, restart_req, connect, cpu_stop} = 6'h20;
        reg_addr = 10'h000;
        reg_wdata = 32'h0000_0000;
        switches_fitted = 1'b1;
        switch_addr = 8'h05;
        r = 32'h773a_6e46;
        errors = 0;
        n_tests = 0;
        rst();
        rd(ad, 32'h0000_0000);
        rd(re, 32'h0000_0001);
        rd(sf, 32'h0000_0000);
        rd(8'h70, 32'h0000_0000);
        // Naming sources and delayed address take-over
        wr(ad, 32'h0000_0000);
        wr(lsp_pkg::SAVE_IDX, 32'h0000_0001);
        rst();
        switches_fitted <= 1'b0;
        wt(8);
        check({31'h0, use_ctrl_name}, 1);
        wr(ad, 32'h0000_0023);
        wt(8);
        check({31'h0, use_ctrl_name}, 1);
        wr(lsp_pkg::SAVE_IDX, 32'h0000_0001);
        restart_req <= 1'b1;
        wt(8);
        restart_req <= 1'b0;
        wt(8);
        check({16'h0, node_addr}, 32'h0000_0023);
        check({31'h0, use_sw_name}, 1);
        // Random switch settings against the saved software address
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            switches_fitted <= r[8];
            switch_addr <= r[7:0];
            wt(8);
            check({16'h0, node_addr}, (r[8] && r[7:0] != 8'h00) ? {24'h0, r[7:0]} : 32'h0000_0023);
        end
        switches_fitted <= 1'b1;
        switch_addr <= 8'h12;
        wt(8);
        check({31'h0, use_switch_addr}, 1);
        switch_addr <= 8'h00;
        wt(8);
        check({31'h0, use_sw_name}, 1);
        // Random targets, signed range
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            wr(sf, r);
            rd(sf, r);
            wr(ad, r);
            rd(ad, {16'h0, r[15:0]});
        end
        check(safe_target, r);
        // No reaction before any connection existed
        wr(re, 32'h0000_0002);
        wt(40);
        // Loss codes then provider-bad codes, all four each
        for (int k = 0; k < 8; k++) begin
            wr(re, k < 4 ? 32'(k % 4) : 32'(k % 4) << 4);
            connect <= 1'b1;
            wt(12);
            if (k % 4 == 2) evq.push_back(2'h1);
            else if (k % 4 != 0) evq.push_back(2'h2);
            connect <= k >= 4;
            cpu_stop <= k >= 4;
            wt(15);
            connect <= 1'b0;
            cpu_stop <= 1'b0;
            wt(15);
        end
        // Interrupt masked, raised and cleared
        wr(mk, 32'h0000_0004);
        check({31'h0, irq}, 0);
        wr(mk, 32'h0000_0007);
        check({31'h0, irq}, 1);
        rd(st, 32'h0000_0003);
        wr(st, 32'h0000_0007);
        rd(st, 32'h0000_0000);
        check({31'h0, irq}, 0);
        // Power-up timeout, all three delays
        for (int c = 1; c < 4; c++) begin
            rst();
            evq.push_back(2'h1);
            wr(re, 32'(c) << 2);
            n = 3;
            while (!safe_run_req && n < 300) begin
                @(negedge clk);
                n++;
            end
            @(posedge clk);
            lim = (c == 1 ? 3 : c == 2 ? 6 : 12) * 10;
            check({31'h0, n >= lim - 15 && n <= lim + 15}, 1);
        end
        wt(5);
        check(32'(evq.size()), 0);
        results();
    end
endmodule
